/* src/clock_source_startup_ctrl.sv */
// Clock source selection, start-up delay, prescale and module clock gating
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module clock_source_startup_ctrl #(
  parameter int unsigned TIMEOUT_SHORT_CYC = clk_startup_pkg::TIMEOUT_SHORT_CYC, // 4 ms in cycles
  parameter int unsigned TIMEOUT_LONG_CYC = clk_startup_pkg::TIMEOUT_LONG_CYC // 64 ms in cycles
) (
  input wire logic pclk, // Bus and system clock
  input wire logic presetn, // Power-on reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [7:0] factory_cal, // Stored calibration value
  input wire logic wake_pin, // Asynchronous wake request
  output logic sys_reset_n, // Internal reset, active low
  output logic sys_clk_tick, // System clock enable after prescale
  output logic pll_clock_sel, // PLL chosen as source
  output logic timer0_clk_en, // Timer 0 clock enable
  output logic serial_clk_en, // Serial unit clock enable
  output logic adc_clk_en, // ADC and comparator clock enable
  output logic [7:0] osc_cal_value // Current calibration value
);

  // ----------------------------------------------------------------
  // Delay selection
  // ----------------------------------------------------------------
  localparam logic [31:0] T_SHORT = 32'(TIMEOUT_SHORT_CYC);
  localparam logic [31:0] T_LONG = 32'(TIMEOUT_LONG_CYC);

  // Total of fixed cycles and timeout, counted as one span
  function automatic logic [31:0] reset_delay(input logic [3:0] src, input logic [1:0] start_sel,
                                              input logic rstdis);
    logic [31:0] d;
    d = clk_startup_pkg::CK_RESET_FIXED;
    if (src == clk_startup_pkg::SRC_PLL) begin
      d = T_SHORT;
    end else begin
      case (start_sel)
        clk_startup_pkg::START_00: begin
          d = rstdis ? clk_startup_pkg::CK_RESET_FIXED + T_SHORT : clk_startup_pkg::CK_RESET_FIXED;
        end
        clk_startup_pkg::START_01: d = clk_startup_pkg::CK_RESET_FIXED + T_SHORT;
        // Reserved code takes the safe long delay
        default: d = clk_startup_pkg::CK_RESET_FIXED + T_LONG;
      endcase
    end
    return d;
  endfunction

  function automatic logic [31:0] wake_delay(input logic [3:0] src, input logic [1:0] start_sel);
    logic [31:0] d;
    d = clk_startup_pkg::CK_WAKE_RC;
    if (src == clk_startup_pkg::SRC_PLL) begin
      case (start_sel)
        clk_startup_pkg::START_00: d = clk_startup_pkg::CK_RESET_FIXED + clk_startup_pkg::CK_PLL_1K + T_SHORT;
        clk_startup_pkg::START_01: d = clk_startup_pkg::CK_RESET_FIXED + clk_startup_pkg::CK_PLL_16K + T_SHORT;
        clk_startup_pkg::START_10: d = clk_startup_pkg::CK_RESET_FIXED + clk_startup_pkg::CK_PLL_1K + T_LONG;
        default: d = clk_startup_pkg::CK_RESET_FIXED + clk_startup_pkg::CK_PLL_16K + T_LONG;
      endcase
    end else begin
      d = clk_startup_pkg::CK_WAKE_RC;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] cal_reg, cal_next;
  logic [2:0] prr_reg, prr_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [2:0] pre_reg, pre_next;
  clk_startup_pkg::startup_state_t state_reg, state_next;
  logic [2:0] wake_sync_reg;
  logic [31:0] rdata_reg, rdata_next;
  logic err_reg, err_next;
  logic rst_n_reg, rst_n_next;
  logic tick_reg, tick_next;
  logic pll_reg, pll_next;
  logic [2:0] en_reg, en_next;

  logic [3:0] cfg_src;
  logic [1:0] cfg_start;
  logic cfg_div8, cfg_rstdis;
  logic setup_phase, access_phase, wr_en, sleep_req, wake_seen, running, addr_ok;

  assign cfg_src = cfg_reg[clk_startup_pkg::CFG_SRC_LSB +: 4];
  assign cfg_start = cfg_reg[clk_startup_pkg::CFG_START_LSB +: 2];
  assign cfg_div8 = cfg_reg[clk_startup_pkg::CFG_DIV8_BIT];
  assign cfg_rstdis = cfg_reg[clk_startup_pkg::CFG_RSTDIS_BIT];
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_en = access_phase & pwrite & ~err_reg;
  assign sleep_req = wr_en & (paddr == clk_startup_pkg::ADDR_CTRL) & pwdata[clk_startup_pkg::CTRL_SLEEP_BIT];
  // Second and third stages must agree before a wake counts
  assign wake_seen = wake_sync_reg[1] & wake_sync_reg[2];
  assign running = (state_reg == clk_startup_pkg::ST_RUN);

  // ----------------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_sync_reg <= 3'h0;
    end else begin
      wake_sync_reg <= {wake_sync_reg[1:0], wake_pin};
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cal_next = cal_reg;
    // Hold until the whole span has run out
    case (state_reg)
      clk_startup_pkg::ST_POR: begin
        cnt_next = reset_delay(cfg_src, cfg_start, cfg_rstdis);
        state_next = clk_startup_pkg::ST_RST_DLY;
        cal_next = factory_cal;
      end
      clk_startup_pkg::ST_RST_DLY: begin
        cal_next = factory_cal;
        if (cnt_reg <= clk_startup_pkg::ONE_CNT) begin
          cnt_next = clk_startup_pkg::ZERO_CNT;
          state_next = clk_startup_pkg::ST_RUN;
        end else begin
          cnt_next = cnt_reg - clk_startup_pkg::ONE_CNT;
        end
      end
      clk_startup_pkg::ST_RUN: begin
        if (wr_en && (paddr == clk_startup_pkg::ADDR_CAL)) begin
          cal_next = pwdata[7:0];
        end
        if (sleep_req) begin
          state_next = clk_startup_pkg::ST_SLEEP;
        end
      end
      clk_startup_pkg::ST_SLEEP: begin
        if (wake_seen) begin
          cnt_next = wake_delay(cfg_src, cfg_start);
          state_next = clk_startup_pkg::ST_WAKE_DLY;
        end
      end
      clk_startup_pkg::ST_WAKE_DLY: begin
        if (cnt_reg <= clk_startup_pkg::ONE_CNT) begin
          cnt_next = clk_startup_pkg::ZERO_CNT;
          state_next = clk_startup_pkg::ST_RUN;
        end else begin
          cnt_next = cnt_reg - clk_startup_pkg::ONE_CNT;
        end
      end
      default: begin
        state_next = clk_startup_pkg::ST_POR;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= clk_startup_pkg::ST_POR;
      cnt_reg <= clk_startup_pkg::ZERO_CNT;
      cal_reg <= clk_startup_pkg::CAL_RESET;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cal_reg <= cal_next;
    end
  end

  // ----------------------------------------------------------------
  // Configuration and power reduction registers
  // ----------------------------------------------------------------
  // Start-up code takes effect at the next wake delay; the reset delay always sees the reset values; source and divide-by-8 act at once
  always_comb begin
    cfg_next = cfg_reg;
    prr_next = prr_reg;
    if (wr_en && (paddr == clk_startup_pkg::ADDR_CFG)) begin
      cfg_next = pwdata[clk_startup_pkg::CFG_WIDTH-1:0];
    end
    if (wr_en && (paddr == clk_startup_pkg::ADDR_PRR)) begin
      prr_next = pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= clk_startup_pkg::CFG_RESET;
      prr_reg <= clk_startup_pkg::PRR_RESET;
    end else begin
      cfg_reg <= cfg_next;
      prr_reg <= prr_next;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and clock enables
  // ----------------------------------------------------------------
  always_comb begin
    pre_next = pre_reg + 3'h1;
    tick_next = 1'b1;
    // RC source is the default, no external parts
    pll_next = (cfg_src == clk_startup_pkg::SRC_PLL);
    // Divide the RC clock by eight
    if (cfg_div8 && !pll_next) begin
      tick_next = (pre_reg == clk_startup_pkg::PRESCALE_LAST);
    end else begin
      pre_next = clk_startup_pkg::PRESCALE_ZERO;
    end
    // No clock enable runs outside the run state
    tick_next = tick_next & (state_next == clk_startup_pkg::ST_RUN);
    rst_n_next = (state_next == clk_startup_pkg::ST_RUN) || (state_next == clk_startup_pkg::ST_SLEEP)
              || (state_next == clk_startup_pkg::ST_WAKE_DLY);
    // Timer 0 gated; its state is kept
    en_next[clk_startup_pkg::PRR_TIMER0_BIT] = tick_next & ~prr_next[clk_startup_pkg::PRR_TIMER0_BIT];
    en_next[clk_startup_pkg::PRR_SERIAL_BIT] = tick_next & ~prr_next[clk_startup_pkg::PRR_SERIAL_BIT];
    en_next[clk_startup_pkg::PRR_ADC_BIT] = tick_next & ~prr_next[clk_startup_pkg::PRR_ADC_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= clk_startup_pkg::PRESCALE_ZERO;
      tick_reg <= 1'b0;
      pll_reg <= 1'b0;
      rst_n_reg <= 1'b0;
      en_reg <= 3'h0;
    end else begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
      pll_reg <= pll_next;
      rst_n_reg <= rst_n_next;
      en_reg <= en_next;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Read data is captured in the setup cycle, so every access has one wait-free access cycle
  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    addr_ok = 1'b1;
    if (setup_phase) begin
      case (paddr)
        clk_startup_pkg::ADDR_CFG: rdata_next = {24'h00_0000, cfg_reg};
        clk_startup_pkg::ADDR_CAL: rdata_next = {24'h00_0000, cal_reg};
        clk_startup_pkg::ADDR_PRR: rdata_next = {29'h0000_0000, prr_reg};
        clk_startup_pkg::ADDR_CTRL: rdata_next = 32'h0000_0000;
        clk_startup_pkg::ADDR_STATUS: rdata_next = {27'h000_0000, tick_reg, running, state_reg};
        clk_startup_pkg::ADDR_DLYCNT: rdata_next = cnt_reg;
        default: begin
          rdata_next = 32'h0000_0000;
          addr_ok = 1'b0;
        end
      endcase
      err_next = ~addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign pready = access_phase;
  assign pslverr = access_phase & err_reg;
  assign prdata = rdata_reg;
  assign sys_reset_n = rst_n_reg;
  assign sys_clk_tick = tick_reg;
  assign pll_clock_sel = pll_reg;
  assign timer0_clk_en = en_reg[clk_startup_pkg::PRR_TIMER0_BIT];
  assign serial_clk_en = en_reg[clk_startup_pkg::PRR_SERIAL_BIT];
  assign adc_clk_en = en_reg[clk_startup_pkg::PRR_ADC_BIT];
  assign osc_cal_value = cal_reg;

endmodule // clock_source_startup_ctrl

`default_nettype wire

/* include/clk_startup_pkg.sv */
// Constants shared by the clock source and start-up delay controller
package clk_startup_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TIMEOUT_SHORT_NS = 4_000_000;
  localparam int unsigned TIMEOUT_LONG_NS = 64_000_000;
  // Least times: round up to whole cycles
  localparam int unsigned TIMEOUT_SHORT_CYC = (TIMEOUT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_LONG_CYC = (TIMEOUT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] CK_RESET_FIXED = 32'h0000_000E;
  localparam logic [31:0] CK_WAKE_RC = 32'h0000_0006;
  localparam logic [31:0] CK_PLL_1K = 32'h0000_0400;
  localparam logic [31:0] CK_PLL_16K = 32'h0000_4000;
  localparam logic [31:0] ZERO_CNT = 32'h0000_0000;
  localparam logic [31:0] ONE_CNT = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CAL = 8'h04;
  localparam logic [7:0] ADDR_PRR = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DLYCNT = 8'h14;

  // ----------------------------------------------------------------
  // Field layout of the configuration register
  // ----------------------------------------------------------------
  localparam int unsigned CFG_SRC_LSB = 0;
  localparam int unsigned CFG_START_LSB = 4;
  localparam int unsigned CFG_DIV8_BIT = 6;
  localparam int unsigned CFG_RSTDIS_BIT = 7;
  localparam int unsigned CFG_WIDTH = 8;
  localparam logic [3:0] SRC_PLL = 4'h1;
  localparam logic [3:0] SRC_RC = 4'h2;
  localparam logic [1:0] START_00 = 2'h0;
  localparam logic [1:0] START_01 = 2'h1;
  localparam logic [1:0] START_10 = 2'h2;
  localparam logic [1:0] START_11 = 2'h3;
  // Delivered state: RC source, start-up code 10, divide-by-8 on, reset pin kept
  localparam logic [7:0] CFG_RESET = 8'h62;

  // ----------------------------------------------------------------
  // Other fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PRR_ADC_BIT = 0;
  localparam int unsigned PRR_SERIAL_BIT = 1;
  localparam int unsigned PRR_TIMER0_BIT = 2;
  localparam logic [2:0] PRR_RESET = 3'h0;
  localparam int unsigned CTRL_SLEEP_BIT = 0;
  localparam logic [7:0] CAL_RESET = 8'h80;
  localparam logic [2:0] PRESCALE_LAST = 3'h7;
  localparam logic [2:0] PRESCALE_ZERO = 3'h0;

  typedef enum logic [2:0] {
    ST_POR,
    ST_RST_DLY,
    ST_RUN,
    ST_SLEEP,
    ST_WAKE_DLY
  } startup_state_t;

endpackage

/* tb/clock_source_startup_ctrl_assertions.sv */
// Concurrent checks on the ports of the clock start-up controller
`timescale 1ns/100ps
`default_nettype none
module clock_source_startup_ctrl_assertions #(
  parameter int unsigned TIMEOUT_SHORT_CYC = 20, // Short timeout in cycles
  parameter int unsigned TIMEOUT_LONG_CYC = 50 // Long timeout in cycles
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic [7:0] factory_cal, // Stored calibration
  input wire logic wake_pin, // Wake request
  input wire logic sys_reset_n, // Internal reset, active low
  input wire logic sys_clk_tick, // System clock enable
  input wire logic pll_clock_sel, // PLL chosen
  input wire logic timer0_clk_en, // Timer 0 enable
  input wire logic serial_clk_en, // Serial unit enable
  input wire logic adc_clk_en, // ADC enable
  input wire logic [7:0] osc_cal_value // Calibration value
);
  logic acc;
  assign acc = psel & penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_wr(logic [7:0] a);
    acc && pwrite && paddr == a;
  endsequence
  property p_ready;
    psel |-> (pready == penable);
  endproperty
  a_ready: assert property (p_ready) else $error("pready not tied to access phase");
  property p_unmapped;
    acc && paddr > clk_startup_pkg::ADDR_DLYCNT |-> pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_quiet;
    !sys_reset_n |-> !sys_clk_tick && !timer0_clk_en && !serial_clk_en && !adc_clk_en;
  endproperty
  a_quiet: assert property (p_quiet) else $error("clock enable while held in reset");
  property p_hold;
    $rose(sys_reset_n) |=> sys_reset_n [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("internal reset dropped after release");
  property p_cal;
    $rose(sys_reset_n) |-> osc_cal_value == factory_cal;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration not loaded");
  property p_timer;
    s_wr(clk_startup_pkg::ADDR_PRR) ##0 pwdata[clk_startup_pkg::PRR_TIMER0_BIT] |=> ##[0:2] !timer0_clk_en [*4];
  endproperty
  a_timer: assert property (p_timer) else $error("timer clock not stopped");
  property p_serial;
    s_wr(clk_startup_pkg::ADDR_PRR) ##0 pwdata[clk_startup_pkg::PRR_SERIAL_BIT] |=> ##[0:2] !serial_clk_en [*4];
  endproperty
  a_serial: assert property (p_serial) else $error("serial clock not stopped");
  property p_adc;
    s_wr(clk_startup_pkg::ADDR_PRR) ##0 pwdata[clk_startup_pkg::PRR_ADC_BIT] |=> ##[0:2] !adc_clk_en [*4];
  endproperty
  a_adc: assert property (p_adc) else $error("adc clock not stopped");
  property p_pll;
    s_wr(clk_startup_pkg::ADDR_CFG) ##0 pwdata[3:0] == clk_startup_pkg::SRC_PLL |=> ##[0:1] pll_clock_sel;
  endproperty
  a_pll: assert property (p_pll) else $error("pll source not selected");
  property p_rc;
    s_wr(clk_startup_pkg::ADDR_CFG) ##0 pwdata[3:0] == clk_startup_pkg::SRC_RC |=> ##[0:1] !pll_clock_sel;
  endproperty
  a_rc: assert property (p_rc) else $error("rc source not selected");
endmodule // clock_source_startup_ctrl_assertions
bind clock_source_startup_ctrl clock_source_startup_ctrl_assertions #(.TIMEOUT_SHORT_CYC(TIMEOUT_SHORT_CYC),
  .TIMEOUT_LONG_CYC(TIMEOUT_LONG_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .factory_cal(factory_cal), .wake_pin(wake_pin), .sys_reset_n(sys_reset_n), .sys_clk_tick(sys_clk_tick),
  .pll_clock_sel(pll_clock_sel), .timer0_clk_en(timer0_clk_en), .serial_clk_en(serial_clk_en),
  .adc_clk_en(adc_clk_en), .osc_cal_value(osc_cal_value));
`default_nettype wire

/* tb/clock_source_startup_ctrl_tb.sv */
// Self-checking bench for the clock start-up controller
`timescale 1ns/100ps
`default_nettype none
module clock_source_startup_ctrl_tb;
  // Short timeouts keep the long start-up delays affordable
  localparam int T_SHORT = 20;
  localparam int T_LONG = 50;
  typedef struct {logic [7:0] cfg; logic [2:0] prr; int tk; int t0; int se; int ad;} row_t;
  logic pclk, presetn, psel, penable, pwrite, wake_pin, pready, pslverr, sys_reset_n, sys_clk_tick;
  logic pll_clock_sel, timer0_clk_en, serial_clk_en, adc_clk_en, err;
  logic [7:0] paddr, factory_cal, osc_cal_value;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch = 0, n_compared = 0, cyc = 0, n, c_tk, c_t0, c_se, c_ad, lo;
  row_t rows [8] = '{'{8'h62, 3'h0, 8, 8, 8, 8}, '{8'h22, 3'h0, 64, 64, 64, 64}, '{8'h22, 3'h7, 64, 0, 0, 0},
    '{8'h22, 3'h4, 64, 0, 64, 64}, '{8'h22, 3'h2, 64, 64, 0, 64}, '{8'h22, 3'h1, 64, 64, 64, 0},
    '{8'h62, 3'h5, 8, 0, 8, 0}, '{8'h61, 3'h0, 64, 64, 64, 64}};

  clock_source_startup_ctrl #(.TIMEOUT_SHORT_CYC(T_SHORT), .TIMEOUT_LONG_CYC(T_LONG)) u_clock_source_startup_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .factory_cal(factory_cal),
    .wake_pin(wake_pin), .sys_reset_n(sys_reset_n), .sys_clk_tick(sys_clk_tick), .pll_clock_sel(pll_clock_sel),
    .timer0_clk_en(timer0_clk_en), .serial_clk_en(serial_clk_en), .adc_clk_en(adc_clk_en),
    .osc_cal_value(osc_cal_value));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic results;
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int lo_b, input int hi_b);
    n_compared++;
    if (got < lo_b || got > hi_b) begin
      n_mismatch++;
      $display("BAD %0t count %0d expected %0d to %0d", $time, got, lo_b, hi_b);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp32(rd, exp);
  endtask
  task automatic wait_for(input bit rst, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (((rst ? sys_reset_n : sys_clk_tick) !== 1'b1) && n < lim);
  endtask
  task automatic count(input int cycles);
    c_tk = 0;
    c_t0 = 0;
    c_se = 0;
    c_ad = 0;
    repeat (cycles) begin
      @(posedge pclk);
      c_tk += int'(sys_clk_tick === 1'b1);
      c_t0 += int'(timer0_clk_en === 1'b1);
      c_se += int'(serial_clk_en === 1'b1);
      c_ad += int'(adc_clk_en === 1'b1);
    end
  endtask
  task automatic do_reset(input logic [7:0] cal);
    presetn <= 1'b0;
    factory_cal <= cal;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(1'b1, 200);
    cmpn(n, 14 + T_LONG, 14 + T_LONG + 3);
    rdchk(clk_startup_pkg::ADDR_CAL, 32'(cal));
  endtask
  task automatic sleep_wake(input int dly);
    apb(1'b1, clk_startup_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    apb(1'b0, clk_startup_pkg::ADDR_STATUS, 32'h0000_0000);
    cmp32(rd & 32'h0000_0007, 32'h0000_0003);
    cmp32(32'(sys_reset_n), 32'h0000_0001);
    wake_pin <= 1'b1;
    wait_for(1'b0, 17000);
    // Three sync stages, the load edge, then one edge to see the tick
    cmpn(n, dly + 5, dly + 5);
    wake_pin <= 1'b0;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    wake_pin = 1'b0;
    factory_cal = 8'h5a;
    do_reset(8'h5a);
    rdchk(clk_startup_pkg::ADDR_CFG, 32'h0000_0062);
    rdchk(clk_startup_pkg::ADDR_PRR, 32'h0000_0000);
    rdchk(clk_startup_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, 8'h18, 32'h0000_00ff);
    cmp32(32'(err), 32'h0000_0001);
    rdchk(8'h18, 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1'b1, clk_startup_pkg::ADDR_CFG, 32'(rows[i].cfg));
      apb(1'b1, clk_startup_pkg::ADDR_PRR, 32'(rows[i].prr));
      repeat (4) @(posedge pclk);
      count(64);
      cmpn(c_tk, rows[i].tk, rows[i].tk);
      cmpn(c_t0, rows[i].t0, rows[i].t0);
      cmpn(c_se, rows[i].se, rows[i].se);
      cmpn(c_ad, rows[i].ad, rows[i].ad);
      cmp32(32'(pll_clock_sel), 32'(rows[i].cfg[3:0] == clk_startup_pkg::SRC_PLL));
      rdchk(clk_startup_pkg::ADDR_PRR, 32'(rows[i].prr));
    end
    // Wake delay for every PLL code, then RC codes 00 to 10
    for (int s = 0; s < 7; s++) begin
      if (s < 4) begin
        apb(1'b1, clk_startup_pkg::ADDR_CFG,
            32'(clk_startup_pkg::SRC_PLL) | (32'(s) << clk_startup_pkg::CFG_START_LSB));
        lo = 14 + (s[0] ? 16384 : 1024) + (s[1] ? T_LONG : T_SHORT);
      end else begin
        apb(1'b1, clk_startup_pkg::ADDR_CFG,
            32'(clk_startup_pkg::SRC_RC) | (32'(s - 4) << clk_startup_pkg::CFG_START_LSB));
        lo = 6;
      end
      sleep_wake(lo);
    end
    // Reset in mid-run reloads a new calibration
    do_reset(8'h3c);
    results();
  end
endmodule // clock_source_startup_ctrl_tb
`default_nettype wire
